// [core/teach_override_bypass.sv]
`timescale 1ns/100ps
`default_nettype none
`include "teach_override_defines.svh"
module teach_override_bypass #(
	parameter int SIMUL_CYC = `SIMUL_WINDOW_CYC,
	parameter int CYC_PER_S = `CLK_HZ
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rstn,
	// Configuration
	input wire teach_override_pkg::ovr_cfg_s cfg,
	// Key button levels
	input wire teach_override_pkg::key_levels_s key,
	// Teach-in and field state
	input wire logic teach_active,
	input wire logic teach_success,
	input wire logic field_clear,
	input wire logic restart_lock_enabled,
	input wire logic start_press,
	// Outputs
	output logic safety_switch_output,
	output logic bypass_active,
	output logic blue_indicator,
	output logic restart_locked
);
	import teach_override_pkg::*;

	////////////////////////////////////////////////////////////////
	// Key decoding
	////////////////////////////////////////////////////////////////

	// Both levels at their idle pattern
	function automatic logic key_at_rest(input key_levels_s k);
		return !k.level_a && k.level_b;
	endfunction

	// Both levels switched over and antivalent
	function automatic logic key_actuated(input key_levels_s k);
		return k.level_a && !k.level_b;
	endfunction

	// One level has switched, the other not yet
	function automatic logic key_halfway(input key_levels_s k);
		return k.level_a == k.level_b;
	endfunction

	// Bypass length in clock cycles
	// A zero limit would leave the bypass unbounded, so it falls back
	// to the factory default instead; the key alone never holds it on
	function automatic logic [31:0] limit_cycles(input logic [15:0] secs);
		logic [15:0] use_secs;
		use_secs = (secs == 16'h0000) ? `TIME_LIMIT_S_DEFAULT : secs;
		return 32'(use_secs) * 32'(CYC_PER_S);
	endfunction

	////////////////////////////////////////////////////////////////
	// Qualifiers
	////////////////////////////////////////////////////////////////

	ovr_state_e state;
	ovr_state_e next_state;
	logic teach_prev;
	logic start_prev;
	wire simul_done;
	wire limit_done;

	wire key_rest = key_at_rest(key);
	wire key_act = key_actuated(key);
	wire key_half = key_halfway(key);

	// Trigger refused outside teach-in or with the function off
	wire allowed = teach_active && cfg.enable;
	wire teach_start = teach_active && !teach_prev;
	wire teach_end = teach_prev && !teach_active;
	// Only a fresh press counts; a button held across the end of
	// teach-in cannot clear the interlock by itself
	wire start_rise = start_press && !start_prev;

	wire next_active = (next_state == ovr_active);
	wire enter_active = next_active && (state != ovr_active);
	wire [31:0] limit_cyc = limit_cycles(cfg.time_limit_s);

	// Window opens on the first level change from rest
	wire start_simul = (state == ovr_idle) && allowed && key_half;
	wire simul_stop = (state != ovr_pending) && !start_simul;
	wire limit_stop = (state != ovr_active) && !next_active;

	////////////////////////////////////////////////////////////////
	// Timers
	////////////////////////////////////////////////////////////////

	// Simultaneity window for the two key levels
	pair_timer #(.WIDTH(32)) u_simul (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.load(start_simul),
		.count(32'(SIMUL_CYC)),
		.stop(simul_stop),
		.running(),
		.done(simul_done)
	);

	// Bypass time limit, reloaded on every entry to the bypass
	pair_timer #(.WIDTH(32)) u_limit (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.load(enter_active),
		.count(limit_cyc),
		.stop(limit_stop),
		.running(),
		.done(limit_done)
	);

	////////////////////////////////////////////////////////////////
	// Bypass sequence
	////////////////////////////////////////////////////////////////

	always_comb begin
		next_state = state;
		case (state)
			ovr_idle: begin
				if (allowed && key_act) begin
					// Both levels changed within one cycle
					next_state = ovr_active;
				end else if (start_simul) begin
					next_state = ovr_pending;
				end else if (!allowed && !key_rest) begin
					// Key moved outside teach-in: refused until rest
					next_state = ovr_wait_rest;
				end
			end
			ovr_pending: begin
				if (!allowed || key_rest) begin
					next_state = ovr_idle;
				end else if (key_act) begin
					next_state = ovr_active;
				end else if (simul_done) begin
					// Second level too slow: refused
					next_state = ovr_wait_rest;
				end
			end
			ovr_active: begin
				// Ending teach-in first also drops the bypass, fail-safe
				if (!allowed || !key_act || limit_done) begin
					next_state = ovr_wait_rest;
				end
			end
			ovr_wait_rest: begin
				// No retrigger until the key is back at rest
				if (key_rest) begin
					next_state = ovr_idle;
				end
			end
			default: begin
				next_state = ovr_idle;
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			state <= ovr_idle;
		end else begin
			state <= next_state;
		end
	end

	// Edge detectors reset low, the level of both pins at rest, so
	// that no false edge follows reset
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			teach_prev <= 1'b0;
			start_prev <= 1'b0;
		end else begin
			teach_prev <= teach_active;
			start_prev <= start_press;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			bypass_active <= 1'b0;
		end else begin
			bypass_active <= next_active;
		end
	end

	////////////////////////////////////////////////////////////////
	// Internal start/restart interlock
	////////////////////////////////////////////////////////////////

	// Set on the end of teach-in, cleared by a start press or while
	// restart_lock_enabled is low; the set wins over a start press in one cycle. The bypass has no path
	// into this flag, so an override never unlocks it.
	wire next_lock = restart_lock_enabled &&
		(teach_end || (restart_locked && !start_rise));

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			restart_locked <= 1'b0;
		end else begin
			restart_locked <= next_lock;
		end
	end

	////////////////////////////////////////////////////////////////
	// Success indicator
	////////////////////////////////////////////////////////////////

	// Success only counts once teach-in has ended; a new teach-in
	// clears it, and the two can never fall in one cycle
	wire blue_set = teach_success && !teach_active;
	wire next_blue = blue_set || (blue_indicator && !teach_start);

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			blue_indicator <= 1'b0;
		end else begin
			blue_indicator <= next_blue;
		end
	end

	////////////////////////////////////////////////////////////////
	// Safety switching output
	////////////////////////////////////////////////////////////////

	// During teach-in the new field is unknown, so only the bypass
	// may switch the output on, whatever the field shows
	wire teach_out = next_active;
	// Outside teach-in the field and the interlock decide
	wire run_out = field_clear && !next_lock;
	wire next_out = teach_active ? teach_out : run_out;

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			safety_switch_output <= 1'b0;
		end else begin
			safety_switch_output <= next_out;
		end
	end
endmodule
`default_nettype wire

// [core/teach_override_defines.svh]
// Functional notes
// - Bypass active in teach-in forces output on
// - Override trigger accepted only during teach-in
// - Both key levels change within 0.5 s
// - Enable setting, default enabled
// - Bypass time limit, default 60 s
// - First input low at rest, high actuated
// - Second input high at rest, low actuated
// - Blue indicator lit after successful teach-in
// - Override never releases internal restart interlock
// - Output off during teach-in without override
`ifndef TEACH_OVERRIDE_DEFINES_SVH
`define TEACH_OVERRIDE_DEFINES_SVH
`define CLK_HZ 32'h0098_9680
`define MS_PER_S 32'h0000_03e8
`define SIMUL_WINDOW_MS 32'h0000_01f4
`define SIMUL_WINDOW_CYC ((`CLK_HZ / `MS_PER_S) * `SIMUL_WINDOW_MS)
`define TIME_LIMIT_S_DEFAULT 16'h003c
`define OVERRIDE_ENABLE_DEFAULT 1'h1
`endif

// [core/teach_override_pkg.sv]
package teach_override_pkg;
	typedef enum logic [1:0] {
		ovr_idle,
		ovr_pending,
		ovr_active,
		ovr_wait_rest
	} ovr_state_e;
	typedef struct packed {
		logic level_a;
		logic level_b;
	} key_levels_s;
	typedef struct packed {
		logic enable;
		logic [15:0] time_limit_s;
	} ovr_cfg_s;
endpackage

// [core/pair_timer.sv]
`timescale 1ns/100ps
`default_nettype none
// Down counter; load starts it, done pulses as it steps from one to zero
module pair_timer #(
	parameter int WIDTH = 32
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rstn,
	// Control
	input wire logic load,
	input wire logic [WIDTH-1:0] count,
	input wire logic stop,
	// Status
	output logic running,
	output logic done
);
	logic [WIDTH-1:0] remain;
	wire last = (remain == {{(WIDTH-1){1'b0}}, 1'b1});
	always_ff @(posedge clk_sys) begin
		if (!rstn || stop) begin
			remain <= '0;
			done <= 1'b0;
		end else if (load) begin
			remain <= count;
			done <= 1'b0;
		end else begin
			done <= last;
			if (remain != '0)
				remain <= remain - {{(WIDTH-1){1'b0}}, 1'b1};
		end
	end
	assign running = (remain != '0);
endmodule
`default_nettype wire

// [verif/teach_override_bypass_props.sv]
`timescale 1ns/100ps
`default_nettype none
module teach_override_bypass_props import teach_override_pkg::*; (
	input wire logic clk_sys, rstn, teach_active, teach_success, restart_lock_enabled,
	input wire ovr_cfg_s cfg,
	input wire key_levels_s key,
	input wire logic safety_switch_output, bypass_active, blue_indicator, restart_locked
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	out_on_a: assert property (bypass_active |-> safety_switch_output) else $error("out");
	teach_off_a: assert property (teach_active && $past(teach_active) && !bypass_active
		|-> !safety_switch_output) else $error("teach");
	no_teach_a: assert property (!teach_active |=> !bypass_active) else $error("idle");
	disabled_a: assert property (!cfg.enable |=> !bypass_active) else $error("off");
	key_start_a: assert property (teach_active && cfg.enable && $past(key) == 2'b01 &&
		key == 2'b10 |=> bypass_active) else $error("start");
	key_lost_a: assert property (bypass_active && key != 2'b10 |=> !bypass_active)
		else $error("lost");
	lock_set_a: assert property ($fell(teach_active) && restart_lock_enabled
		|-> ##[1:2] restart_locked) else $error("lock");
	blue_on_a: assert property (teach_success && !teach_active |-> ##[1:2] blue_indicator)
		else $error("blue");
	cover property (bypass_active);
	cover property ($fell(bypass_active) && key == 2'b10);
	cover property ($fell(restart_locked));
endmodule
bind teach_override_bypass teach_override_bypass_props chk_u (
	.clk_sys(clk_sys),
	.rstn(rstn),
	.teach_active(teach_active),
	.teach_success(teach_success),
	.restart_lock_enabled(restart_lock_enabled),
	.cfg(cfg),
	.key(key),
	.safety_switch_output(safety_switch_output),
	.bypass_active(bypass_active),
	.blue_indicator(blue_indicator),
	.restart_locked(restart_locked)
);
`default_nettype wire

// [verif/key_button.sv]
`timescale 1ns/100ps
`default_nettype none
// Level a leads; level b follows skew cycles later
module key_button import teach_override_pkg::*; (
	input wire logic clk_sys,
	input wire logic press,
	input wire logic [15:0] skew,
	output wire key_levels_s key
);
	logic [15:0] n = 16'h0000;
	logic a = 1'b0;
	logic b = 1'b1;
	always @(posedge clk_sys) begin
		n <= press ? n + 16'h0001 : 16'h0000;
		a <= press;
		b <= !(press && n >= skew);
	end
	assign key = '{level_a: a, level_b: b};
endmodule
`default_nettype wire

// [verif/teach_override_bypass_test.sv]
`timescale 1ns/100ps
`default_nettype none
`include "teach_override_defines.svh"
module teach_override_bypass_test;
	import teach_override_pkg::*;
	logic clk_sys = 1'b0, rstn = 1'b0, press = 1'b0, teach_active = 1'b0;
	logic teach_success = 1'b0, field_clear = 1'b0, restart_lock_enabled = 1'b0;
	logic start_press = 1'b0;
	logic safety_switch_output, bypass_active, blue_indicator, restart_locked;
	logic [15:0] skew = 16'h0000;
	ovr_cfg_s cfg = '{`OVERRIDE_ENABLE_DEFAULT, 16'h0003};
	key_levels_s key;
	int errors = 0, num_checks = 0, ticks = 0;
	always #50 clk_sys = !clk_sys;
	key_button key_u (
		.clk_sys(clk_sys),
		.press(press),
		.skew(skew),
		.key(key)
	);
	teach_override_bypass #(.SIMUL_CYC(20), .CYC_PER_S(10)) dut_u (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.cfg(cfg),
		.key(key),
		.teach_active(teach_active),
		.teach_success(teach_success),
		.field_clear(field_clear),
		.restart_lock_enabled(restart_lock_enabled),
		.start_press(start_press),
		.safety_switch_output(safety_switch_output),
		.bypass_active(bypass_active),
		.blue_indicator(blue_indicator),
		.restart_locked(restart_locked)
	);
	task cyc(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	task chk(input string s, input logic e, g);
		num_checks++;
		if (g !== e) begin
			errors++;
			$display("[FAIL] %s exp %b got %b", s, e, g);
		end
	endtask
	task hit(input logic [15:0] k, input int n, input logic e);
		@(posedge clk_sys);
		skew <= k;
		press <= 1'b1;
		cyc(n);
		@(negedge clk_sys);
		chk("bypass", e, bypass_active);
		chk("output", e, safety_switch_output);
		@(posedge clk_sys);
		press <= 1'b0;
		cyc(3);
		@(negedge clk_sys);
		chk("released", 1'b0, bypass_active);
	endtask
	task complete_run;
		if (errors == 0 && num_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	always @(posedge clk_sys) begin
		ticks <= ticks + 1;
		if (ticks == 1000) begin
			errors++;
			complete_run;
		end
	end
	initial begin
		cyc(20);
		@(negedge clk_sys);
		chk("rst bypass", 1'b0, bypass_active);
		chk("rst output", 1'b0, safety_switch_output);
		chk("rst blue", 1'b0, blue_indicator);
		chk("rst locked", 1'b0, restart_locked);
		@(posedge clk_sys);
		rstn <= 1'b1;
		hit(16'h0000, 4, 1'b0);
		// Key held from before teach-in stays refused
		@(posedge clk_sys);
		press <= 1'b1;
		cyc(3);
		teach_active <= 1'b1;
		cyc(4);
		@(negedge clk_sys);
		chk("held", 1'b0, bypass_active);
		@(posedge clk_sys);
		press <= 1'b0;
		cyc(3);
		hit(16'h0000, 3, 1'b1);
		hit(16'h0005, 10, 1'b1);
		hit(16'h001e, 40, 1'b0);
		hit(16'h0000, 20, 1'b1);
		hit(16'h0000, 36, 1'b0);
		@(posedge clk_sys);
		cfg.time_limit_s <= 16'h0000;
		hit(16'h0000, 40, 1'b1);
		@(posedge clk_sys);
		cfg.enable <= 1'b0;
		hit(16'h0000, 4, 1'b0);
		@(posedge clk_sys);
		cfg.enable <= 1'b1;
		restart_lock_enabled <= 1'b1;
		teach_active <= 1'b0;
		teach_success <= 1'b1;
		field_clear <= 1'b1;
		@(posedge clk_sys);
		teach_success <= 1'b0;
		cyc(3);
		@(negedge clk_sys);
		chk("blue", 1'b1, blue_indicator);
		chk("locked", 1'b1, restart_locked);
		chk("output", 1'b0, safety_switch_output);
		@(posedge clk_sys);
		start_press <= 1'b1;
		cyc(2);
		start_press <= 1'b0;
		cyc(3);
		@(negedge clk_sys);
		chk("output", 1'b1, safety_switch_output);
		chk("unlocked", 1'b0, restart_locked);
		complete_run;
	end
endmodule
`default_nettype wire
